// *** i2c_data_and_check_registers_bench.sv ***
`default_nettype none

module i2c_data_and_check_registers_bench
	import i2cdr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk_i = 1'b0;
	logic        rst_i     = 1'b1;
	logic [7:0]  addr_i    = 8'h00;
	logic [31:0] wdata_i   = 32'h0000_0000;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic        unit_on_i = 1'b1;
	logic        chk_en    = 1'b0;
	logic [7:0]  chk_val   = 8'h00;
	logic        tx_take   = 1'b0;
	logic [7:0]  rx_count  = 8'h00;
	logic [31:0] rdata, alt_rdata, v, alt_v;
	logic        rx_valid, rx_ready, tx_empty, rx_full;
	logic [7:0]  rx_byte, tx_byte;
	int          n_errors = 0;
	int          compares = 0;

	i2cdr_top i2cdr_top_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .unit_on_i(unit_on_i),
		.check_enable_i(chk_en), .check_value_i(chk_val), .rx_valid_i(rx_valid),
		.rx_byte_i(rx_byte), .rx_ready_o(rx_ready), .tx_take_i(tx_take), .tx_byte_o(tx_byte),
		.tx_holding_empty_o(tx_empty), .rx_holding_full_o(rx_full));

	// A build without the check register, read alongside the main one.
	i2cdr_top #(.SMBUS_SUPPORT(1'b0)) i2cdr_top_inst_b (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(alt_rdata),
		.unit_on_i(unit_on_i), .check_enable_i(chk_en), .check_value_i(chk_val),
		.rx_valid_i(1'b0), .rx_byte_i(8'h00), .rx_ready_o(), .tx_take_i(1'b0), .tx_byte_o(),
		.tx_holding_empty_o(), .rx_holding_full_o());

	i2cdr_engine_model i2cdr_engine_model_inst (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.ready_i(rx_ready), .unit_on_i(unit_on_i), .count_i(rx_count), .valid_o(rx_valid),
		.byte_o(rx_byte));

	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		v     = rdata;
		alt_v = alt_rdata;
	endtask : rd

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : close_out

	// The whole run needs well under 1000 cycles.
	initial begin
		#50us;
		n_errors++;
		close_out();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge sys_clk_i);
		rst_i <= 1'b0;

		rd(I2CDR_OFS_CHECK);    chk("check reset", 32'h0000_0000, v);
		rd(I2CDR_OFS_RECEIVE);  chk("receive reset", 32'h0000_0000, v);
		rd(I2CDR_OFS_TRANSMIT); chk("transmit reset", 32'h0000_0000, v);
		rd(I2CDR_OFS_FLAGS);    chk("flags reset", 32'h0000_0001, v);
		rd(8'h30);              chk("unmapped", 32'h0000_0000, v);
		$display("test reset values done");

		wr(I2CDR_OFS_TRANSMIT, 32'h0000_00A5);
		chk("tx empty after write", 32'h0, {31'h0, tx_empty});
		rd(I2CDR_OFS_TRANSMIT); chk("transmit", 32'h0000_00A5, v);
		wr(I2CDR_OFS_TRANSMIT, 32'h0000_005A);
		chk("tx byte kept", 32'hA5, {24'h0, tx_byte});
		@(posedge sys_clk_i);
		tx_take <= 1'b1;
		@(posedge sys_clk_i);
		tx_take <= 1'b0;
		#1;
		chk("tx empty after take", 32'h1, {31'h0, tx_empty});
		wr(I2CDR_OFS_TRANSMIT, 32'h0000_005A);
		chk("tx byte", 32'h5A, {24'h0, tx_byte});
		wr(I2CDR_OFS_FLAGS, 32'h0000_0001);
		chk("tx empty after flush", 32'h1, {31'h0, tx_empty});
		$display("test transmit done");

		// Software stalls while the engine offers more than holder plus queue can take.
		@(posedge sys_clk_i);
		rx_count <= 8'd20;
		repeat (40) @(posedge sys_clk_i);
		#1;
		chk("rx ready when full", 32'h0, {31'h0, rx_ready});
		chk("rx full", 32'h1, {31'h0, rx_full});
		for (int k = 0; k < 20; k++) begin
			rd(I2CDR_OFS_RECEIVE); chk("receive", 32'h10 + k, v);
			repeat (3) @(posedge sys_clk_i);
		end
		#1;
		chk("rx full after drain", 32'h0, {31'h0, rx_full});
		$display("test receive done");

		@(posedge sys_clk_i);
		chk_en   <= 1'b1;
		chk_val  <= 8'hC3;
		rx_count <= 8'd21;
		rd(I2CDR_OFS_CHECK);    chk("check", 32'h0000_00C3, v);
		chk("check absent", 32'h0000_0000, alt_v);
		wr(I2CDR_OFS_CHECK, 32'h0000_00FF);
		rd(I2CDR_OFS_CHECK);    chk("check write", 32'h0000_00C3, v);
		chk("check absent write", 32'h0000_0000, alt_v);
		@(posedge sys_clk_i);
		chk_en  <= 1'b0;
		chk_val <= 8'h3C;
		rd(I2CDR_OFS_CHECK);    chk("check held", 32'h0000_00C3, v);
		wr(I2CDR_OFS_TRANSMIT, 32'h0000_0077);
		chk("rx full before off", 32'h1, {31'h0, rx_full});
		@(posedge sys_clk_i);
		unit_on_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rd(I2CDR_OFS_CHECK);    chk("check unit off", 32'h0000_0000, v);
		rd(I2CDR_OFS_FLAGS);    chk("flags unit off", 32'h0000_0001, v);
		$display("test check value done");

		close_out();
	end
endmodule : i2c_data_and_check_registers_bench

`default_nettype wire

// *** i2cdr_check_hold.sv ***
`default_nettype none

module i2cdr_check_hold
	import i2cdr_pkg::*;
#(
	parameter bit SMBUS_SUPPORT = 1'b1
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       unit_on_i,
	input  wire logic       check_enable_i,
	input  wire logic [7:0] check_value_i,
	output logic      [7:0] value_o
);
	typedef struct packed {
		logic [7:0] value;
	} i2cdr_check_s;

	i2cdr_check_s state_reg;
	i2cdr_check_s state_next;

	always_comb begin
		state_next = state_reg;
		if (!SMBUS_SUPPORT || !unit_on_i) begin
			state_next.value = I2CDR_RST_BYTE;
		end else if (check_enable_i) begin
			state_next.value = check_value_i;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign value_o = state_reg.value;

	a_check_cleared: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!unit_on_i |=> value_o == 8'h00)
		else $error("check value not cleared while unit off");
	a_check_absent: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!SMBUS_SUPPORT |-> value_o == 8'h00)
		else $error("check value nonzero without SMBus support");

endmodule : i2cdr_check_hold

`default_nettype wire

// *** i2cdr_engine_model.sv ***
`default_nettype none

// ----------------------------------------------------------------
// Bus engine stand-in: offers count_i bytes 0x10, 0x11, ... in turn
// ----------------------------------------------------------------
module i2cdr_engine_model (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       ready_i,
	input  wire logic       unit_on_i,
	input  wire logic [7:0] count_i,
	output logic            valid_o,
	output logic      [7:0] byte_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] sent_reg;

	// An idle byte line shows the inverse of the last byte, so a stale value never matches.
	assign valid_o = sent_reg < count_i;
	assign byte_o  = valid_o ? 8'h10 + sent_reg : ~(8'h0F + sent_reg);

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sent_reg <= 8'h00;
		end else if (valid_o && ready_i && unit_on_i) begin
			sent_reg <= sent_reg + 8'h01;
		end
	end
endmodule : i2cdr_engine_model

`default_nettype wire

// *** i2cdr_fifo.sv ***
`default_nettype none

module i2cdr_fifo
	import i2cdr_pkg::*;
#(
	parameter int WIDTH = I2CDR_FIFO_WIDTH,
	parameter int DEPTH = I2CDR_FIFO_DEPTH
) (
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	input  wire logic             in_valid_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  in_ready_o,
	output logic                  out_valid_o,
	output logic      [WIDTH-1:0] out_data_o,
	input  wire logic             out_ready_i
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_shape
		$error("i2cdr_fifo: DEPTH must be a power of two of at least 2");
	end

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr_ptr;
		logic [AW-1:0]               rd_ptr;
		logic [CW-1:0]               count;
		logic                        ready;
		logic                        valid;
	} i2cdr_fifo_s;

	i2cdr_fifo_s state_reg;
	i2cdr_fifo_s state_next;
	logic        push;
	logic        pop;

	assign push = in_valid_i & state_reg.ready;
	assign pop  = state_reg.valid & out_ready_i;

	always_comb begin
		state_next = state_reg;
		if (push) begin
			state_next.mem[state_reg.wr_ptr] = in_data_i;
			state_next.wr_ptr = state_reg.wr_ptr + AW'(1);
		end
		if (pop) begin
			state_next.rd_ptr = state_reg.rd_ptr + AW'(1);
		end
		state_next.count = state_reg.count + CW'(push) - CW'(pop);
		// Flags are registered so the fill side sees back-pressure from a flip-flop.
		state_next.ready = state_next.count != CW'(DEPTH);
		state_next.valid = state_next.count != CW'(0);
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg       <= '0;
			state_reg.ready <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign in_ready_o  = state_reg.ready;
	assign out_valid_o = state_reg.valid;
	assign out_data_o  = state_reg.mem[state_reg.rd_ptr];

endmodule : i2cdr_fifo

`default_nettype wire

// *** i2cdr_pkg.sv ***
`default_nettype none

package i2cdr_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] I2CDR_OFS_FLAGS    = 8'h18;
	localparam logic [7:0] I2CDR_OFS_CHECK    = 8'h20;
	localparam logic [7:0] I2CDR_OFS_RECEIVE  = 8'h24;
	localparam logic [7:0] I2CDR_OFS_TRANSMIT = 8'h28;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int I2CDR_BYTE_MSB        = 7;
	localparam int I2CDR_FLAG_TX_EMPTY   = 0;
	localparam int I2CDR_FLAG_RX_FULL    = 1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] I2CDR_RST_WORD     = 32'h0000_0000;
	localparam logic [7:0]  I2CDR_RST_BYTE     = 8'h00;
	localparam logic        I2CDR_RST_TX_EMPTY = 1'b1;
	localparam logic        I2CDR_RST_RX_FULL  = 1'b0;

	// ----------------------------------------------------------------
	// Receive buffer shape
	// ----------------------------------------------------------------
	localparam int I2CDR_FIFO_DEPTH = 16;
	localparam int I2CDR_FIFO_WIDTH = 8;

endpackage : i2cdr_pkg

`default_nettype wire

// *** i2cdr_top.sv ***
// Our own choice: the strobed register port.

`default_nettype none

module i2cdr_top
	import i2cdr_pkg::*;
#(
	parameter bit SMBUS_SUPPORT = 1'b1,
	parameter int FIFO_DEPTH    = I2CDR_FIFO_DEPTH
) (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// Register port.
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	// Controls from the rest of the controller.
	input  wire logic        unit_on_i,
	input  wire logic        check_enable_i,
	input  wire logic [7:0]  check_value_i,
	// Bytes arriving from the bus engine.
	input  wire logic        rx_valid_i,
	input  wire logic [7:0]  rx_byte_i,
	output logic             rx_ready_o,
	// Byte handed to the bus engine, and the two holder flags.
	input  wire logic        tx_take_i,
	output logic      [7:0]  tx_byte_o,
	output logic             tx_holding_empty_o,
	output logic             rx_holding_full_o
);

	// The queue wraps its pointers by plain overflow, so only powers of two
	// of at least two entries can be served.
	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("i2cdr_top: FIFO_DEPTH must be a power of two of at least 2");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  rx_byte;
		logic        rx_full;
		logic [7:0]  tx_byte;
		logic        tx_empty;
		logic [31:0] rdata;
	} i2cdr_top_s;

	i2cdr_top_s state_reg;
	i2cdr_top_s state_next;

	logic       fifo_ready;
	logic       fifo_valid;
	logic [7:0] fifo_data;
	logic       fifo_pop;
	logic [7:0] check_byte;

	logic       wr_tx;
	logic       wr_flags;
	logic       rd_rx;

	// ----------------------------------------------------------------
	// Submodules
	// ----------------------------------------------------------------
	// Bytes queue here so that a slow software reader stalls the bus
	// engine through rx_ready_o rather than losing data.
	i2cdr_fifo #(
		.WIDTH (I2CDR_FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (rx_valid_i & unit_on_i),
		.in_data_i   (rx_byte_i),
		.in_ready_o  (fifo_ready),
		.out_valid_o (fifo_valid),
		.out_data_o  (fifo_data),
		.out_ready_i (fifo_pop)
	);

	i2cdr_check_hold #(
		.SMBUS_SUPPORT (SMBUS_SUPPORT)
	) u_check (
		.sys_clk_i      (sys_clk_i),
		.rst_i          (rst_i),
		.unit_on_i      (unit_on_i),
		.check_enable_i (check_enable_i),
		.check_value_i  (check_value_i),
		.value_o        (check_byte)
	);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	assign wr_tx    = wr_i && addr_i == I2CDR_OFS_TRANSMIT;
	assign wr_flags = wr_i && addr_i == I2CDR_OFS_FLAGS;
	assign rd_rx    = rd_i && addr_i == I2CDR_OFS_RECEIVE;

	// A new byte loads when the holder is free or is being read in this
	// very cycle, so the load wins over the read clear.
	assign fifo_pop = unit_on_i && (!state_reg.rx_full || rd_rx);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_next       = state_reg;
		state_next.rdata = I2CDR_RST_WORD;

		// Receive holder.
		if (rd_rx) begin
			state_next.rx_full = 1'b0;
		end
		if (fifo_pop && fifo_valid) begin
			state_next.rx_byte = fifo_data;
			state_next.rx_full = 1'b1;
		end

		// Transmit holder.
		if (tx_take_i && !state_reg.tx_empty) begin
			state_next.tx_empty = 1'b1;
		end
		if (wr_tx && state_reg.tx_empty) begin
			state_next.tx_byte  = wdata_i[I2CDR_BYTE_MSB:0];
			state_next.tx_empty = 1'b0;
		end
		if (wr_flags && wdata_i[I2CDR_FLAG_TX_EMPTY]) begin
			state_next.tx_empty = 1'b1;
		end

		// Read data stand for one cycle only; upper bits stay zero.
		if (rd_i) begin
			case (addr_i)
				I2CDR_OFS_CHECK: begin
					state_next.rdata[I2CDR_BYTE_MSB:0] = check_byte;
				end
				I2CDR_OFS_RECEIVE: begin
					state_next.rdata[I2CDR_BYTE_MSB:0] = state_reg.rx_byte;
				end
				I2CDR_OFS_TRANSMIT: begin
					state_next.rdata[I2CDR_BYTE_MSB:0] = state_reg.tx_byte;
				end
				I2CDR_OFS_FLAGS: begin
					state_next.rdata[I2CDR_FLAG_TX_EMPTY] = state_reg.tx_empty;
					state_next.rdata[I2CDR_FLAG_RX_FULL]  = state_reg.rx_full;
				end
				default: begin
					state_next.rdata = I2CDR_RST_WORD;
				end
			endcase
		end

		// Turning the unit off empties both holders; the stored transmit
		// byte is kept so a read still shows what was last written.
		if (!unit_on_i) begin
			state_next.rx_full  = I2CDR_RST_RX_FULL;
			state_next.tx_empty = I2CDR_RST_TX_EMPTY;
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg          <= '0;
			state_reg.tx_empty <= I2CDR_RST_TX_EMPTY;
		end else begin
			state_reg <= state_next;
		end
	end

	// The FIFO's ready comes from its own flag flip-flop.
	assign rx_ready_o         = fifo_ready;
	assign rdata_o            = state_reg.rdata;
	assign tx_byte_o          = state_reg.tx_byte;
	assign tx_holding_empty_o = state_reg.tx_empty;
	assign rx_holding_full_o  = state_reg.rx_full;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	a_tx_write_taken: assert property (
		wr_tx && tx_holding_empty_o && unit_on_i
		|=> tx_byte_o == $past(wdata_i[7:0]) && !tx_holding_empty_o)
		else $error("transmit write while empty not taken");

	a_tx_write_refused: assert property (
		wr_tx && !tx_holding_empty_o |=> $stable(tx_byte_o))
		else $error("transmit byte changed by write while full");

	a_tx_flush: assert property (
		wr_flags && wdata_i[0] |=> tx_holding_empty_o)
		else $error("flush did not empty transmit holder");

	a_tx_take: assert property (
		tx_take_i && !tx_holding_empty_o && !wr_i |=> tx_holding_empty_o)
		else $error("take did not empty transmit holder");

	a_unit_off_flags: assert property (
		!unit_on_i |=> tx_holding_empty_o && !rx_holding_full_o)
		else $error("flags wrong while unit off");

	a_rx_read_clear: assert property (
		rd_rx && rx_holding_full_o && !fifo_valid |=> !rx_holding_full_o)
		else $error("receive read did not clear full flag");

	a_rx_load_byte: assert property (
		fifo_pop && fifo_valid
		|=> rx_holding_full_o && state_reg.rx_byte == $past(fifo_data))
		else $error("receive holder did not load queued byte");

	a_rd_upper_zero: assert property (
		rd_i |=> rdata_o[31:8] == 24'h000000)
		else $error("reserved read bits not zero");

	a_rd_check_value: assert property (
		rd_i && addr_i == I2CDR_OFS_CHECK |=> rdata_o[7:0] == $past(check_byte))
		else $error("check register read wrong value");

	a_rd_one_cycle: assert property (
		!rd_i |=> rdata_o == 32'h00000000)
		else $error("read data stood without a read");

	// ----------------------------------------------------------------
	// Read path and holder stability
	// ----------------------------------------------------------------
	// Each field is compared with the flop it came from a cycle earlier,
	// so a wrong decode shows even when the byte happens to be zero.
	// The flags word is compared as a pair so swapped bits are caught.
	a_rd_receive_value: assert property (
		rd_i && addr_i == I2CDR_OFS_RECEIVE |=> rdata_o[7:0] == $past(state_reg.rx_byte))
		else $error("receive register read wrong value");

	a_rd_transmit_value: assert property (
		rd_i && addr_i == I2CDR_OFS_TRANSMIT |=> rdata_o[7:0] == $past(tx_byte_o))
		else $error("transmit register read wrong value");

	a_rd_flags_value: assert property (
		rd_i && addr_i == I2CDR_OFS_FLAGS
		|=> rdata_o[1:0] == $past({rx_holding_full_o, tx_holding_empty_o}))
		else $error("flags register read wrong value");

	a_rd_absent_check: assert property (
		!SMBUS_SUPPORT && rd_i && addr_i == I2CDR_OFS_CHECK |=> rdata_o == 32'h00000000)
		else $error("check register nonzero without SMBus support");

	// Reserved offsets must never echo stale data from another register.
	a_rd_unmapped_zero: assert property (
		rd_i && addr_i != I2CDR_OFS_CHECK && addr_i != I2CDR_OFS_RECEIVE
		&& addr_i != I2CDR_OFS_TRANSMIT && addr_i != I2CDR_OFS_FLAGS |=> rdata_o == 32'h00000000)
		else $error("unmapped read gave nonzero data");

	// A byte changing under a full holder would be lost with no flag raised.
	a_rx_byte_stands: assert property (
		!(fifo_pop && fifo_valid) |=> $stable(state_reg.rx_byte))
		else $error("receive byte changed without a load");

	a_rx_full_holds: assert property (
		rx_holding_full_o && !rd_rx && unit_on_i |=> rx_holding_full_o)
		else $error("receive full flag dropped without a read");

	// A free holder never leaves a queued byte waiting while the unit is on.
	a_rx_load_free: assert property (
		unit_on_i && fifo_valid && !rx_holding_full_o |=> rx_holding_full_o)
		else $error("free receive holder did not take a queued byte");

	a_tx_byte_stands: assert property (
		!wr_tx |=> $stable(tx_byte_o))
		else $error("transmit byte changed without a write");

	// Only a take, a flush or the unit going off may empty the holder.
	a_tx_empty_holds: assert property (
		!tx_holding_empty_o && !tx_take_i && !wr_flags && unit_on_i
		|=> !tx_holding_empty_o)
		else $error("transmit empty flag rose without take or flush");

	// ----------------------------------------------------------------
	// Coverage
	// ----------------------------------------------------------------
	// These mark the scenarios that the bench is expected to reach; a hole
	// here means the assertions above were never really exercised.
	c_tx_write: cover property (wr_tx && tx_holding_empty_o ##1 tx_take_i);
	c_rx_load_read: cover property (fifo_pop && fifo_valid ##[1:4] rd_rx);
	c_fifo_full: cover property (!fifo_ready);
	c_flush: cover property (wr_flags && wdata_i[0] && !tx_holding_empty_o);
	c_unit_off_full: cover property (rx_holding_full_o && !unit_on_i);

endmodule : i2cdr_top

`default_nettype wire
